// File: adc_input_select_result_format.sv
// Converter control: enable, input selection, conversion sequencing, result format, APB registers.
`timescale 1ns/1ps
module adc_input_select_result_format
  import adc_ctrl_pkg::*;
#(
  parameter int CONV_CYCLES = CONV_CYCLES_DEFAULT
) (
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [CODE_W-1:0] sar_code_in,
  output logic shutdown_out,
  output input_sel_t mux_sel_out,
  output logic differential_mode_out,
  output logic convert_out,
  output logic irq_out
);
  // ==========================================================================
  // Elaboration check: the down counter is eight bits wide.
  if (CONV_CYCLES < 2 || CONV_CYCLES > 256) begin : g_bad_cycles
    $error("CONV_CYCLES must lie between 2 and 256");
  end

  // ==========================================================================
  // State.
  logic en, next_en;
  logic ljst, next_ljst;
  input_sel_t sel, next_sel;
  sel_info_t info, next_info;
  logic [IRQ_W-1:0] status, next_status;
  logic [IRQ_W-1:0] irq_en, next_irq_en;
  conv_state_t state, next_state;
  logic [7:0] cnt, next_cnt;
  result_t result, next_result;
  result_t fmt;
  logic [CODE_W-1:0] code_meta, code_sync;
  logic [31:0] next_prdata, rd_data;
  logic next_pready, next_pslverr, next_irq;
  logic wr_fire, setup, mapped;
  logic start_req, start_ok, refused, done_ev;
  logic [IRQ_W-1:0] clear_mask;

  // ==========================================================================
  // Sub-blocks.
  input_mux_decode #(
    .PINS(PIN_COUNT)
  ) u_decode (
    .sel_in(next_sel),
    .info_out(next_info)
  );

  result_formatter u_format (
    .code_in(code_sync),
    .differential_in(info.differential),
    .left_justify_in(ljst),
    .result_out(fmt)
  );

  // ==========================================================================
  // Bus phases: a setup cycle prepares the answer, the access cycle commits it.
  assign setup = psel_in && !penable_in;
  assign wr_fire = psel_in && penable_in && pready_out && pwrite_in;

  // Read multiplexer and address decode.
  always_comb begin
    rd_data = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr_in == OFS_CONTROL) begin
      rd_data[CTL_EN_BIT] = en;
      rd_data[CTL_DONE_BIT] = status[IRQ_DONE];
      rd_data[CTL_BUSY_BIT] = (state == CONV_RUN);
      rd_data[CTL_LJST_BIT] = ljst;
    end else if (paddr_in == OFS_POS_SEL) begin
      rd_data[SEL_W-1:0] = sel.pos;
    end else if (paddr_in == OFS_NEG_SEL) begin
      rd_data[SEL_W-1:0] = sel.neg;
    end else if (paddr_in == OFS_RES_HIGH) begin
      rd_data[7:0] = result.high;
    end else if (paddr_in == OFS_RES_LOW) begin
      rd_data[7:0] = result.low;
    end else if (paddr_in == OFS_IRQ_STATUS) begin
      rd_data[IRQ_W-1:0] = status;
    end else if (paddr_in == OFS_IRQ_CLEAR) begin
      rd_data = 32'h0000_0000;
    end else if (paddr_in == OFS_IRQ_ENABLE) begin
      rd_data[IRQ_W-1:0] = irq_en;
    end else begin
      mapped = 1'b0;
    end
  end

  // Register writes; result registers ignore writes.
  always_comb begin
    next_en = en;
    next_ljst = ljst;
    next_sel = sel;
    next_irq_en = irq_en;
    start_req = 1'b0;
    clear_mask = '0;
    if (wr_fire) begin
      if (paddr_in == OFS_CONTROL) begin
        next_en = pwdata_in[CTL_EN_BIT];
        next_ljst = pwdata_in[CTL_LJST_BIT];
        start_req = pwdata_in[CTL_BUSY_BIT];
      end else if (paddr_in == OFS_POS_SEL) begin
        next_sel.pos = pwdata_in[SEL_W-1:0];
      end else if (paddr_in == OFS_NEG_SEL) begin
        next_sel.neg = pwdata_in[SEL_W-1:0];
      end else if (paddr_in == OFS_IRQ_CLEAR) begin
        clear_mask = pwdata_in[IRQ_W-1:0];
      end else if (paddr_in == OFS_IRQ_ENABLE) begin
        next_irq_en = pwdata_in[IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Conversion sequencer: a start needs enable, an idle converter and legal inputs.
  assign start_ok = start_req && next_en && (state == CONV_IDLE) && info.pos_valid && info.neg_valid;
  assign refused = start_req && !start_ok;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_result = result;
    done_ev = 1'b0;
    case (state)
      CONV_IDLE: begin
        if (start_ok) begin
          next_state = CONV_RUN;
          next_cnt = 8'(CONV_CYCLES - 1);
        end
      end
      CONV_RUN: begin
        if (!next_en) begin
          next_state = CONV_IDLE;
        end else if (cnt == 8'h00) begin
          next_state = CONV_IDLE;
          next_result = fmt;
          done_ev = 1'b1;
        end else begin
          next_cnt = cnt - 8'h01;
        end
      end
      default: begin
        next_state = CONV_IDLE;
      end
    endcase
  end

  // Sticky events: a new event wins over a clear in the same cycle.
  always_comb begin
    next_status = status & ~clear_mask;
    next_status[IRQ_DONE] = next_status[IRQ_DONE] | done_ev;
    next_status[IRQ_REFUSED] = next_status[IRQ_REFUSED] | refused;
    next_irq = |(next_status & next_irq_en);
    next_pready = setup;
    next_pslverr = setup && !mapped;
    next_prdata = setup ? rd_data : prdata_out;
  end

  // ==========================================================================
  // Code from the analog core is held stable at the end; two stages resample it.
  always_ff @(posedge ref_clk_in) begin
    code_meta <= sar_code_in;
    code_sync <= code_meta;
  end

  // Registers of the block.
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      en <= 1'b0;
      ljst <= 1'b0;
      sel <= {POS_SEL_RESET, NEG_SEL_RESET};
      info <= '0;
      status <= '0;
      irq_en <= '0;
      state <= CONV_IDLE;
      cnt <= 8'h00;
      result <= '0;
      prdata_out <= 32'h0000_0000;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      shutdown_out <= 1'b1;
      mux_sel_out <= {POS_SEL_RESET, NEG_SEL_RESET};
      differential_mode_out <= 1'b0;
      convert_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      en <= next_en;
      ljst <= next_ljst;
      sel <= next_sel;
      info <= next_info;
      status <= next_status;
      irq_en <= next_irq_en;
      state <= next_state;
      cnt <= next_cnt;
      result <= next_result;
      prdata_out <= next_prdata;
      pready_out <= next_pready;
      pslverr_out <= next_pslverr;
      shutdown_out <= !next_en;
      mux_sel_out <= next_sel;
      differential_mode_out <= next_info.differential;
      convert_out <= (next_state == CONV_RUN);
      irq_out <= next_irq;
    end
  end

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  // Helper: cycles spent in the current conversion.
  int run_len;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in || state == CONV_IDLE) begin
      run_len <= 0;
    end else begin
      run_len <= run_len + 1;
    end
  end

  sequence s_accept;
    state == CONV_IDLE && start_ok;
  endsequence

  sequence s_finish;
    state == CONV_RUN && done_ev;
  endsequence

  property p_shutdown;
    !en |-> shutdown_out && state == CONV_IDLE && !convert_out;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("converter active while disabled");

  property p_accept;
    s_accept |=> convert_out && state == CONV_RUN ##1 state == CONV_RUN;
  endproperty
  a_accept: assert property (p_accept) else $error("accepted start did not begin a conversion");

  property p_run_len;
    s_finish |-> run_len == CONV_CYCLES - 1;
  endproperty
  a_run_len: assert property (p_run_len) else $error("conversion length is wrong");

  property p_done;
    s_finish |=> status[IRQ_DONE] && !convert_out && (irq_out == |(status & irq_en));
  endproperty
  a_done: assert property (p_done) else $error("done flag or interrupt missing at conversion end");

  property p_load;
    s_finish |=> result == $past(fmt);
  endproperty
  a_load: assert property (p_load) else $error("result not loaded at conversion end");

  property p_mode;
    differential_mode_out == (mux_sel_out.neg != NEG_GND);
  endproperty
  a_mode: assert property (p_mode) else $error("mode does not follow negative selection");

  property p_right;
    !ljst |-> {fmt.high[1:0], fmt.low} == code_sync
      && fmt.high[7:2] == (info.differential ? {6{code_sync[CODE_W-1]}} : 6'h00);
  endproperty
  a_right: assert property (p_right) else $error("right-justified format wrong");

  property p_left;
    ljst |-> {fmt.high, fmt.low[7:6]} == code_sync && fmt.low[5:0] == 6'h00;
  endproperty
  a_left: assert property (p_left) else $error("left-justified format wrong");

  property p_refused;
    start_req && state == CONV_RUN |=> status[IRQ_REFUSED];
  endproperty
  a_refused: assert property (p_refused) else $error("refused start not flagged");

  property p_bus;
    setup |=> pready_out ##1 !pready_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");
endmodule : adc_input_select_result_format

// File: adc_ctrl_pkg.sv
// Shared constants, register map and carrier types of the converter control block.
package adc_ctrl_pkg;
  // ==========================================================================
  // Widths.
  localparam int CODE_W = 10;
  localparam int SEL_W = 5;
  localparam int ADDR_W = 8;
  localparam int IRQ_W = 2;
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_POS_SEL = 8'h04;
  localparam logic [7:0] OFS_NEG_SEL = 8'h08;
  localparam logic [7:0] OFS_RES_HIGH = 8'h0C;
  localparam logic [7:0] OFS_RES_LOW = 8'h10;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;
  // ==========================================================================
  // Field positions of the control register and of the interrupt registers.
  localparam int CTL_LJST_BIT = 0;
  localparam int CTL_BUSY_BIT = 4;
  localparam int CTL_DONE_BIT = 5;
  localparam int CTL_EN_BIT = 7;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_REFUSED = 1;
  // ==========================================================================
  // Selection codes and values after reset.
  localparam logic [4:0] SEL_PIN_LAST = 5'h10;
  localparam logic [4:0] SEL_TEMP = 5'h1E;
  localparam logic [4:0] SEL_VDD = 5'h1F;
  localparam logic [4:0] NEG_VREF = 5'h1E;
  localparam logic [4:0] NEG_GND = 5'h1F;
  localparam logic [4:0] POS_SEL_RESET = 5'h00;
  localparam logic [4:0] NEG_SEL_RESET = 5'h1F;
  localparam int PIN_COUNT = 17;
  localparam int CONV_CYCLES_DEFAULT = 16;
  // ==========================================================================
  // Types.
  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_RUN = 1'b1
  } conv_state_t;
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } result_t;
  typedef struct packed {
    logic [SEL_W-1:0] pos;
    logic [SEL_W-1:0] neg;
  } input_sel_t;
  typedef struct packed {
    logic pos_valid;
    logic neg_valid;
    logic differential;
  } sel_info_t;
endpackage : adc_ctrl_pkg

// File: input_mux_decode.sv
// Decoder of the positive and negative multiplexer selections.
`timescale 1ns/1ps
module input_mux_decode
  import adc_ctrl_pkg::*;
#(
  parameter int PINS = PIN_COUNT
) (
  input wire input_sel_t sel_in,
  output sel_info_t info_out
);
  // ==========================================================================
  // Elaboration check.
  if (PINS != int'(SEL_PIN_LAST) + 1) begin : g_bad_pins
    $error("pin count does not match the selection codes");
  end
  // ==========================================================================
  // Pins, temperature sensor and supply are legal positive inputs.
  always_comb begin
    info_out.pos_valid = (sel_in.pos <= SEL_PIN_LAST) || (sel_in.pos == SEL_TEMP) || (sel_in.pos == SEL_VDD);
    info_out.neg_valid = (sel_in.neg <= SEL_PIN_LAST) || (sel_in.neg == NEG_VREF) || (sel_in.neg == NEG_GND);
    info_out.differential = (sel_in.neg != NEG_GND);
  end
endmodule : input_mux_decode

// File: result_formatter.sv
// Placement of a 10-bit code into the high and low result bytes.
`timescale 1ns/1ps
module result_formatter
  import adc_ctrl_pkg::*;
(
  input wire logic [CODE_W-1:0] code_in,
  input wire logic differential_in,
  input wire logic left_justify_in,
  output result_t result_out
);
  // ==========================================================================
  // Left alignment pads zeros below; right alignment pads zeros or sign above.
  always_comb begin
    if (left_justify_in) begin
      result_out = {code_in, 6'h00};
    end else if (differential_in) begin
      result_out = {{6{code_in[CODE_W-1]}}, code_in};
    end else begin
      result_out = {6'h00, code_in};
    end
  end
endmodule : result_formatter

// File: test_adc_input_select_result_format.sv
// Self-checking testbench of the converter control block.
`timescale 1ns/1ps
module test_adc_input_select_result_format;
  import adc_ctrl_pkg::*;
  localparam int CYC = 4;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [ADDR_W-1:0] paddr_in = '0;
  logic [31:0] pwdata_in = '0;
  logic [CODE_W-1:0] sar_code_in = '0;
  logic [31:0] prdata_out;
  logic pready_out, pslverr_out, shutdown_out, differential_mode_out, convert_out, irq_out;
  input_sel_t mux_sel_out;
  int fails = 0;
  int n_checks = 0;
  int seed = 32'hcc90_afd6;
  logic [31:0] rd;
  logic err;
  // ==========================================================================
  // Clock and device; the short run length keeps the test quick.
  always #2.5 ref_clk_in = ~ref_clk_in;
  adc_input_select_result_format #(.CONV_CYCLES(CYC)) u_dut (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sar_code_in(sar_code_in),
    .shutdown_out(shutdown_out), .mux_sel_out(mux_sel_out),
    .differential_mode_out(differential_mode_out), .convert_out(convert_out), .irq_out(irq_out));
  // ==========================================================================
  // Verdict and report.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : check
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int n;
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= addr;
    pwdata_in <= data;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      complete_run();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    @(posedge ref_clk_in);
  endtask : apb
  // Expected 16-bit result for a code, a mode and an alignment.
  function automatic logic [15:0] expect_result(logic [9:0] code, logic diff, logic lj);
    if (lj) begin
      return {code, 6'h00};
    end
    return diff ? {{6{code[9]}}, code} : {6'h00, code};
  endfunction : expect_result
  // Maps a random number onto a legal selection code.
  function automatic logic [4:0] pick(int v);
    return (v < 17) ? v[4:0] : ((v == 17) ? SEL_TEMP : SEL_VDD);
  endfunction : pick
  // Waits a bounded time for a conversion to start, then measures how long it runs.
  task automatic run_length(output int n);
    n = 0;
    while (convert_out !== 1'b1 && n < 10) begin
      @(posedge ref_clk_in);
      n++;
    end
    n = 0;
    while (convert_out === 1'b1 && n < 300) begin
      n++;
      @(posedge ref_clk_in);
    end
  endtask : run_length
  // Runs one conversion and checks result bytes, status and interrupt.
  task automatic convert(input logic [9:0] code, input logic lj, input logic [4:0] pos,
                         input logic [4:0] neg, input logic irq_en);
    logic [15:0] exp;
    logic diff;
    int n;
    diff = (neg != NEG_GND);
    sar_code_in <= code;
    apb(1'b1, OFS_POS_SEL, {27'h0, pos});
    apb(1'b1, OFS_NEG_SEL, {27'h0, neg});
    check("differential", 32'(diff), 32'(differential_mode_out));
    check("mux select", {22'h0, pos, neg}, {22'h0, mux_sel_out});
    apb(1'b1, OFS_CONTROL, {24'h0, 8'h90} | 32'(lj));
    run_length(n);
    check("run length", CYC, n);
    exp = expect_result(code, diff, lj);
    apb(1'b0, OFS_RES_HIGH, '0);
    check("result high", {24'h0, exp[15:8]}, rd);
    apb(1'b0, OFS_RES_LOW, '0);
    check("result low", {24'h0, exp[7:0]}, rd);
    check("irq", 32'(irq_en), 32'(irq_out));
    apb(1'b0, OFS_IRQ_STATUS, '0);
    check("status", 32'h0000_0001, rd);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0003);
    apb(1'b0, OFS_IRQ_STATUS, '0);
    check("irq cleared", 32'h0000_0000, rd | 32'(irq_out));
  endtask : convert
  // ==========================================================================
  // Main sequence.
  initial begin
    logic [7:0] ofs [7];
    logic [31:0] rst [7];
    int n;
    ofs = '{OFS_CONTROL, OFS_POS_SEL, OFS_NEG_SEL, OFS_RES_HIGH, OFS_RES_LOW, OFS_IRQ_STATUS, OFS_IRQ_ENABLE};
    rst = '{32'h0, 32'h0, 32'h0000_001F, 32'h0, 32'h0, 32'h0, 32'h0};
    repeat (16) @(posedge ref_clk_in);
    srst_in <= 1'b0;
    @(posedge ref_clk_in);
    check("shutdown at reset", 32'h1, 32'(shutdown_out));
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], '0);
      check("reset value", rst[i], rd);
    end
    apb(1'b0, 8'h20, '0);
    check("unmapped error", 32'h1, {rd[30:0], err});
    $display("test reset and map done");
    // A start while disabled is refused and no conversion runs.
    apb(1'b1, OFS_CONTROL, 32'h0000_0010);
    run_length(n);
    check("disabled start", 32'h0, n);
    apb(1'b0, OFS_IRQ_STATUS, '0);
    check("refused flag", 32'h0000_0002, rd);
    apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0003);
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0000_0001);
    apb(1'b1, OFS_CONTROL, 32'h0000_0080);
    check("shutdown off", 32'h0, 32'(shutdown_out));
    $display("test enable done");
    // Full scale and most negative codes in both alignments.
    convert(10'h3FF, 1'b0, 5'h00, NEG_GND, 1'b1);
    convert(10'h3FF, 1'b1, SEL_TEMP, NEG_GND, 1'b1);
    convert(10'h200, 1'b0, SEL_VDD, NEG_VREF, 1'b1);
    convert(10'h200, 1'b1, SEL_PIN_LAST, 5'h10, 1'b1);
    $display("test corner codes done");
    for (int i = 0; i < 16; i++) begin
      convert(10'($random(seed)), 1'($random(seed)), pick(($random(seed) & 32'h7fff_ffff) % 19),
              pick(($random(seed) & 32'h7fff_ffff) % 19), 1'b1);
    end
    $display("test random conversions done");
    // A masked event still sets the status bit but not the interrupt.
    apb(1'b1, OFS_IRQ_ENABLE, 32'h0);
    convert(10'h155, 1'b0, 5'h05, 5'h07, 1'b0);
    // Clearing the enable bit mid-run aborts with no done flag.
    apb(1'b1, OFS_CONTROL, 32'h0000_0090);
    apb(1'b1, OFS_CONTROL, 32'h0);
    apb(1'b0, OFS_IRQ_STATUS, '0);
    check("abort no done", 32'h0, {rd[31:1], rd[0] | convert_out});
    apb(1'b1, OFS_CONTROL, 32'h0000_0080);
    apb(1'b1, OFS_POS_SEL, 32'h0000_0011);
    apb(1'b1, OFS_CONTROL, 32'h0000_0090);
    apb(1'b0, OFS_IRQ_STATUS, '0);
    check("reserved select refused", 32'h0000_0002, rd);
    // A second start while busy is refused and the running conversion still completes.
    apb(1'b1, OFS_IRQ_CLEAR, 32'h0000_0003);
    apb(1'b1, OFS_POS_SEL, 32'h0000_0000);
    apb(1'b1, OFS_CONTROL, 32'h0000_0090);
    apb(1'b1, OFS_CONTROL, 32'h0000_0090);
    apb(1'b0, OFS_IRQ_STATUS, '0);
    check("busy start refused", 32'h0000_0003, rd);
    // Result registers ignore writes and keep the last differential right-justified code.
    apb(1'b1, OFS_RES_HIGH, 32'h0000_00FF);
    apb(1'b0, OFS_RES_HIGH, '0);
    check("result write ignored", 32'h0000_0001, rd);
    $display("test mask abort reserved done");
    complete_run();
  end
endmodule : test_adc_input_select_result_format
